// ==== dlw_top.sv ====
// Limit warnings, initial ramp select and fill-mode setpoint sequencer.
// Assumes drive-core inputs on the same clock and a register master on the plain port.
`timescale 1ns/1ps
`include "dlw_regs.svh"

module dlw_top #(
   parameter int unsigned FILL_TICK_CYC = `DLW_FILL_TICK_NS / `DLW_CLK_PERIOD_NS
) (
   input  wire logic                   i_ref_clk,
   input  wire logic                   i_rst,
   input  wire dlw_pkg::dlw_req_t      i_req,
   input  wire dlw_pkg::dlw_drive_t    i_drive,
   output logic [31:0]                 o_rdata,
   output dlw_pkg::dlw_warn_t          o_warn,
   output logic                        o_sig_warn,
   output logic                        o_relay_warn,
   output logic signed [31:0]          o_setpoint,
   output logic                        o_fill_active,
   output dlw_pkg::dlw_ramp_t          o_ramp
);
   import dlw_pkg::*;

   // Refuse tick counts that the 24-bit divider cannot hold
   if (FILL_TICK_CYC < 2 || FILL_TICK_CYC > 32'h00ff_ffff) begin : g_bad_tick
      $error("FILL_TICK_CYC out of range");
   end

   // Clamp a signed value into [lo, hi]
   function automatic logic signed [31:0] clamp(input logic signed [31:0] v,
                                                input logic signed [31:0] lo,
                                                input logic signed [31:0] hi);
      if (v < lo) begin
         clamp = lo;
      end else if (v > hi) begin
         clamp = hi;
      end else begin
         clamp = v;
      end
   endfunction : clamp

   // Register state
   logic [31:0]        ctrl_q, ctrl_d;
   logic signed [31:0] ref_low_q, ref_low_d, ref_high_q, ref_high_d;
   logic signed [31:0] fb_low_q, fb_low_d, fb_high_q, fb_high_d;
   logic signed [31:0] cur_low_q, cur_low_d, cur_high_q, cur_high_d;
   logic signed [31:0] frq_low_q, frq_low_d, frq_high_q, frq_high_d;
   logic [15:0]        iramp_q, iramp_d;
   logic [31:0]        rate_q, rate_d;
   logic signed [31:0] filled_q, filled_d;
   logic signed [31:0] sp1_q, sp1_d, sp2_q, sp2_d;
   logic signed [31:0] fb_min_q, fb_min_d, ref_max_q, ref_max_d, min_freq_q, min_freq_d;
   logic [15:0]        route_q, route_d;
   logic [31:0]        rdata_q, rdata_d;

   // Warning and state registers
   logic               armed_q, armed_d;
   dlw_warn_t          warn_q, warn_d;
   logic               sig_q, sig_d, rel_q, rel_d;
   dlw_fill_st_t       fill_q, fill_d;
   dlw_iramp_st_t      ir_q, ir_d;
   logic signed [63:0] sp_acc_q, sp_acc_d;
   logic               sp_up_q, sp_up_d;
   logic [23:0]        tick_cnt_q, tick_cnt_d;
   logic signed [31:0] setpt_q, setpt_d;
   logic               fill_act_q, fill_act_d;
   dlw_ramp_t          ramp_q, ramp_d;

   logic               closed, remote, normal_op, sp2_sel, fill_ok, gate, tick;
   logic signed [31:0] wval, op_sp, ref_low_in, ref_high_in;
   logic signed [63:0] filled_micro, fb_micro, rate_micro;

   assign closed    = ctrl_q[`DLW_CTRL_CLOSED_BIT];
   assign remote    = ctrl_q[`DLW_CTRL_REMOTE_BIT];
   assign normal_op = ctrl_q[`DLW_CTRL_NORMAL_BIT];
   assign sp2_sel   = ctrl_q[`DLW_CTRL_SP2_BIT];
   assign wval      = i_req.wdata;
   assign fill_ok   = closed && (rate_q != 32'h0) && normal_op;
   assign op_sp     = sp2_sel ? sp2_q : sp1_q;

   // Register writes with range limits, and read data one cycle later
   always_comb begin
      ctrl_d = ctrl_q;
      ref_low_d = ref_low_q;
      ref_high_d = ref_high_q;
      fb_low_d = fb_low_q;
      fb_high_d = fb_high_q;
      cur_low_d = cur_low_q;
      cur_high_d = cur_high_q;
      frq_low_d = frq_low_q;
      frq_high_d = frq_high_q;
      iramp_d = iramp_q;
      rate_d = rate_q;
      filled_d = filled_q;
      sp1_d = sp1_q;
      sp2_d = sp2_q;
      fb_min_d = fb_min_q;
      ref_max_d = ref_max_q;
      min_freq_d = min_freq_q;
      route_d = route_q;
      rdata_d = 32'h0;
      if (i_req.wr) begin
         unique case (i_req.addr)
            `DLW_CTRL_OFS:      ctrl_d     = {28'h0, i_req.wdata[3:0]};
            `DLW_REF_LOW_OFS:   ref_low_d  = clamp(wval, `DLW_LIMIT_MIN, ref_high_q);
            `DLW_REF_HIGH_OFS:  ref_high_d = clamp(wval, ref_low_q, `DLW_LIMIT_MAX);
            `DLW_FB_LOW_OFS:    fb_low_d   = clamp(wval, `DLW_LIMIT_MIN, fb_high_q);
            `DLW_FB_HIGH_OFS:   fb_high_d  = clamp(wval, fb_low_q, `DLW_LIMIT_MAX);
            `DLW_CURR_LOW_OFS:  cur_low_d  = clamp(wval, 32'sh0, cur_high_q);
            `DLW_CURR_HIGH_OFS: cur_high_d = clamp(wval, cur_low_q, `DLW_LIMIT_MAX);
            `DLW_FREQ_LOW_OFS:  frq_low_d  = clamp(wval, 32'sh0, frq_high_q);
            `DLW_FREQ_HIGH_OFS: frq_high_d = clamp(wval, frq_low_q, `DLW_LIMIT_MAX);
            `DLW_INIT_RAMP_OFS: iramp_d    = (i_req.wdata[31:16] != 16'h0 ||
                                              i_req.wdata[15:0] > `DLW_INIT_RAMP_MAX) ?
                                             `DLW_INIT_RAMP_MAX : i_req.wdata[15:0];
            `DLW_FILL_RATE_OFS: rate_d     = 32'(clamp(wval, 32'sh0, `DLW_LIMIT_MAX));
            `DLW_FILLED_SP_OFS: filled_d   = clamp(wval, fb_min_q, ref_max_q);
            `DLW_SETPT1_OFS:    sp1_d      = wval;
            `DLW_SETPT2_OFS:    sp2_d      = wval;
            `DLW_FB_MIN_OFS:    fb_min_d   = wval;
            `DLW_REF_MAX_OFS:   ref_max_d  = wval;
            `DLW_MIN_FREQ_OFS:  min_freq_d = wval;
            `DLW_ROUTE_OFS:     route_d    = i_req.wdata[15:0];
            default: ;
         endcase
      end
      if (i_req.rd) begin
         unique case (i_req.addr)
            `DLW_CTRL_OFS:      rdata_d = ctrl_q;
            `DLW_REF_LOW_OFS:   rdata_d = ref_low_q;
            `DLW_REF_HIGH_OFS:  rdata_d = ref_high_q;
            `DLW_FB_LOW_OFS:    rdata_d = fb_low_q;
            `DLW_FB_HIGH_OFS:   rdata_d = fb_high_q;
            `DLW_CURR_LOW_OFS:  rdata_d = cur_low_q;
            `DLW_CURR_HIGH_OFS: rdata_d = cur_high_q;
            `DLW_FREQ_LOW_OFS:  rdata_d = frq_low_q;
            `DLW_FREQ_HIGH_OFS: rdata_d = frq_high_q;
            `DLW_INIT_RAMP_OFS: rdata_d = {16'h0, iramp_q};
            `DLW_FILL_RATE_OFS: rdata_d = rate_q;
            `DLW_FILLED_SP_OFS: rdata_d = filled_q;
            `DLW_SETPT1_OFS:    rdata_d = sp1_q;
            `DLW_SETPT2_OFS:    rdata_d = sp2_q;
            `DLW_FB_MIN_OFS:    rdata_d = fb_min_q;
            `DLW_REF_MAX_OFS:   rdata_d = ref_max_q;
            `DLW_MIN_FREQ_OFS:  rdata_d = min_freq_q;
            `DLW_ROUTE_OFS:     rdata_d = {16'h0, route_q};
            `DLW_STATUS_OFS:    rdata_d = {19'h0, ir_q, fill_q, armed_q, warn_q};
            `DLW_FILL_SP_OFS:   rdata_d = setpt_q;
            default:            rdata_d = 32'h0;
         endcase
      end
   end

   // Register storage
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         ctrl_q <= `DLW_CTRL_RST;
         ref_low_q <= `DLW_LIMIT_MIN;
         ref_high_q <= `DLW_LIMIT_MAX;
         fb_low_q <= `DLW_LIMIT_MIN;
         fb_high_q <= `DLW_LIMIT_MAX;
         cur_low_q <= `DLW_ZERO_RST;
         cur_high_q <= `DLW_LIMIT_MAX;
         frq_low_q <= `DLW_ZERO_RST;
         frq_high_q <= `DLW_LIMIT_MAX;
         iramp_q <= `DLW_INIT_RAMP_OFF;
         rate_q <= `DLW_ZERO_RST;
         filled_q <= `DLW_ZERO_RST;
         sp1_q <= `DLW_ZERO_RST;
         sp2_q <= `DLW_ZERO_RST;
         fb_min_q <= `DLW_ZERO_RST;
         ref_max_q <= `DLW_LIMIT_MAX;
         min_freq_q <= `DLW_ZERO_RST;
         route_q <= 16'(`DLW_ROUTE_RST);
         rdata_q <= `DLW_ZERO_RST;
      end else begin
         ctrl_q <= ctrl_d;
         ref_low_q <= ref_low_d;
         ref_high_q <= ref_high_d;
         fb_low_q <= fb_low_d;
         fb_high_q <= fb_high_d;
         cur_low_q <= cur_low_d;
         cur_high_q <= cur_high_d;
         frq_low_q <= frq_low_d;
         frq_high_q <= frq_high_d;
         iramp_q <= iramp_d;
         rate_q <= rate_d;
         sp1_q <= sp1_d;
         sp2_q <= sp2_d;
         ref_max_q <= ref_max_d;
         min_freq_q <= min_freq_d;
         route_q <= route_d;
         rdata_q <= rdata_d;
         // Filled setpoint follows its own bounds when they move
         fb_min_q <= fb_min_d;
         filled_q <= clamp(filled_d, fb_min_d, ref_max_d);
      end
   end

   // Warning gating, comparisons and routing
   always_comb begin
      gate = i_drive.running && !i_drive.ramp_up && !i_drive.ramp_down;
      armed_d = armed_q;
      if (!gate) begin
         armed_d = 1'b0;
      end else if (i_drive.at_reference) begin
         armed_d = 1'b1;
      end
      ref_low_in  = closed ? i_drive.remote_ref_pu : i_drive.remote_ref_hz;
      ref_high_in = closed ? i_drive.result_ref_pu : i_drive.result_ref_hz;
      warn_d = '0;
      if (gate && armed_q) begin
         warn_d.ref_low   = remote && (ref_low_in < ref_low_q);
         warn_d.ref_high  = remote && (ref_high_in > ref_high_q);
         warn_d.fb_low    = i_drive.feedback < fb_low_q;
         warn_d.fb_high   = i_drive.feedback > fb_high_q;
         warn_d.curr_low  = i_drive.current < cur_low_q;
         warn_d.curr_high = i_drive.current > cur_high_q;
         warn_d.freq_low  = i_drive.out_freq < frq_low_q;
         warn_d.freq_high = i_drive.out_freq > frq_high_q;
      end
      sig_d = |(warn_q & route_q[`DLW_ROUTE_SIG_LSB +: 8]);
      rel_d = |(warn_q & route_q[`DLW_ROUTE_REL_LSB +: 8]);
   end

   // Warning registers; recomputed every cycle so they drop at once
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         armed_q <= 1'b0;
         warn_q  <= '0;
         sig_q   <= 1'b0;
         rel_q   <= 1'b0;
      end else begin
         armed_q <= armed_d;
         warn_q  <= warn_d;
         sig_q   <= sig_d;
         rel_q   <= rel_d;
      end
   end

   // Initial ramp select: from standstill up to minimum frequency
   always_comb begin
      ir_d   = ir_q;
      ramp_d = '{initial_sel: 1'b0, time_tenths: iramp_q};
      unique case (ir_q)
         IR_IDLE: begin
            if (i_drive.start_cmd && i_drive.out_freq <= 32'sh0) begin
               ir_d = (iramp_q != `DLW_INIT_RAMP_OFF) ? IR_INIT : IR_NORM;
            end
         end
         IR_INIT: begin
            // A zero time written mid-ramp hands over to the normal ramp
            ramp_d.initial_sel = (iramp_q != `DLW_INIT_RAMP_OFF);
            if (!i_drive.start_cmd) begin
               ir_d = IR_IDLE;
            end else if (i_drive.out_freq >= min_freq_q || iramp_q == `DLW_INIT_RAMP_OFF) begin
               ir_d = IR_NORM;
            end
         end
         IR_NORM: begin
            if (!i_drive.start_cmd && !i_drive.running) begin
               ir_d = IR_IDLE;
            end
         end
         default: ir_d = IR_IDLE;
      endcase
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         ir_q   <= IR_IDLE;
         ramp_q <= '0;
      end else begin
         ir_q   <= ir_d;
         ramp_q <= ramp_d;
      end
   end

   // Fill sequencer; setpoint held in millionths so that a 1 ms step of
   // rate thousandths/s is exact
   assign tick         = (tick_cnt_q == 24'(FILL_TICK_CYC - 1));
   assign filled_micro = 64'(filled_q) * 64'sd1000;
   assign fb_micro     = 64'(i_drive.feedback) * 64'sd1000;
   assign rate_micro   = 64'(rate_q);   // Never negative; signed keeps sums signed

   always_comb begin
      fill_d     = fill_q;
      sp_acc_d   = sp_acc_q;
      sp_up_d    = sp_up_q;
      tick_cnt_d = tick ? 24'h0 : tick_cnt_q + 24'h1;
      setpt_d    = op_sp;
      fill_act_d = 1'b0;
      unique case (fill_q)
         FL_IDLE: begin
            if (i_drive.start_cmd && fill_ok) begin
               fill_d = FL_WAIT;
            end
         end
         FL_WAIT: begin
            if (!i_drive.start_cmd || !fill_ok) begin
               fill_d = FL_IDLE;
            end else if (i_drive.out_freq >= min_freq_q) begin
               fill_d     = FL_RAMP;
               sp_acc_d   = fb_micro;
               sp_up_d    = filled_q >= i_drive.feedback;
               tick_cnt_d = 24'h0;
            end
         end
         FL_RAMP: begin
            fill_act_d = 1'b1;
            setpt_d    = 32'(sp_acc_q / 64'sd1000);
            if (!i_drive.start_cmd || !fill_ok) begin
               fill_d     = FL_IDLE;
               fill_act_d = 1'b0;
               setpt_d    = op_sp;
            end else if (sp_up_q ? (i_drive.feedback >= filled_q)
                                 : (i_drive.feedback <= filled_q)) begin
               fill_d     = FL_DONE;
               fill_act_d = 1'b0;
               setpt_d    = op_sp;
            end else if (tick) begin
               if (sp_up_q) begin
                  sp_acc_d = (sp_acc_q + rate_micro > filled_micro) ?
                             filled_micro : sp_acc_q + rate_micro;
               end else begin
                  sp_acc_d = (sp_acc_q - rate_micro < filled_micro) ?
                             filled_micro : sp_acc_q - rate_micro;
               end
            end
         end
         FL_DONE: begin
            if (!i_drive.start_cmd && !i_drive.running) begin
               fill_d = FL_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         fill_q     <= FL_IDLE;
         sp_acc_q   <= 64'sh0;
         sp_up_q    <= 1'b0;
         tick_cnt_q <= 24'h0;
         setpt_q    <= 32'sh0;
         fill_act_q <= 1'b0;
      end else begin
         fill_q     <= fill_d;
         sp_acc_q   <= sp_acc_d;
         sp_up_q    <= sp_up_d;
         tick_cnt_q <= tick_cnt_d;
         setpt_q    <= setpt_d;
         fill_act_q <= fill_act_d;
      end
   end

   // Outputs straight from flip-flops
   assign o_rdata       = rdata_q;
   assign o_warn        = warn_q;
   assign o_sig_warn    = sig_q;
   assign o_relay_warn  = rel_q;
   assign o_setpoint    = setpt_q;
   assign o_fill_active = fill_act_q;
   assign o_ramp        = ramp_q;

endmodule : dlw_top

// ==== dlw_regs.svh ====
// Register offsets, field positions, reset values and timing figures of the
// limit warning, initial ramp and fill-mode block.
// Assumes 32-bit register words at byte addresses; values are signed thousandths, initial ramp time in tenths.
`ifndef DLW_REGS_SVH
`define DLW_REGS_SVH

// Register byte offsets
`define DLW_CTRL_OFS        8'h00
`define DLW_REF_LOW_OFS     8'h04
`define DLW_REF_HIGH_OFS    8'h08
`define DLW_FB_LOW_OFS      8'h0c
`define DLW_FB_HIGH_OFS     8'h10
`define DLW_INIT_RAMP_OFS   8'h14
`define DLW_FILL_RATE_OFS   8'h18
`define DLW_FILLED_SP_OFS   8'h1c
`define DLW_SETPT1_OFS      8'h20
`define DLW_SETPT2_OFS      8'h24
`define DLW_FB_MIN_OFS      8'h28
`define DLW_REF_MAX_OFS     8'h2c
`define DLW_ROUTE_OFS       8'h30
`define DLW_STATUS_OFS      8'h34
`define DLW_FILL_SP_OFS     8'h38
`define DLW_CURR_LOW_OFS    8'h3c
`define DLW_CURR_HIGH_OFS   8'h40
`define DLW_FREQ_LOW_OFS    8'h44
`define DLW_FREQ_HIGH_OFS   8'h48
`define DLW_MIN_FREQ_OFS    8'h4c

// Control register fields
`define DLW_CTRL_CLOSED_BIT 0
`define DLW_CTRL_REMOTE_BIT 1
`define DLW_CTRL_NORMAL_BIT 2
`define DLW_CTRL_SP2_BIT    3

// Route register fields: signal outputs in 7:0, relays in 15:8
`define DLW_ROUTE_SIG_LSB   0
`define DLW_ROUTE_REL_LSB   8

// Status register fields
`define DLW_STAT_WARN_LSB   0
`define DLW_STAT_ARMED_BIT  8
`define DLW_STAT_FILL_LSB   9
`define DLW_STAT_IRAMP_LSB  11

// Limits and reset values in thousandths
`define DLW_LIMIT_MIN       32'shc4653601
`define DLW_LIMIT_MAX       32'sh3b9ac9ff
`define DLW_CTRL_RST        32'h0000_0004
`define DLW_ROUTE_RST       32'h0000_0000
`define DLW_ZERO_RST        32'h0000_0000

// Initial ramp time in tenths of a second
`define DLW_INIT_RAMP_MAX   16'h0e10
`define DLW_INIT_RAMP_OFF   16'h0000

// Timing
`define DLW_CLK_PERIOD_NS   4
`define DLW_FILL_TICK_NS    1000000

`endif

// ==== dlw_pkg.sv ====
// Types of the limit warning, initial ramp and fill-mode block.
// Assumes dlw_regs.svh carries the numeric constants.
package dlw_pkg;

   // Inputs from the drive core, same clock domain
   typedef struct packed {
      logic               running;        // Motor turning or start active
      logic               start_cmd;      // Start command present
      logic               ramp_up;        // Ramping up after start
      logic               ramp_down;      // Ramping down after stop
      logic               at_reference;   // Output frequency reached reference
      logic signed [31:0] out_freq;       // Output frequency, mHz
      logic signed [31:0] remote_ref_hz;  // Remote reference, open loop
      logic signed [31:0] remote_ref_pu;  // Remote reference, process units
      logic signed [31:0] result_ref_hz;  // Resulting reference, open loop
      logic signed [31:0] result_ref_pu;  // Resulting reference, process units
      logic signed [31:0] feedback;       // Pressure feedback, process units
      logic signed [31:0] current;        // Motor current, mA
   } dlw_drive_t;

   // Warning vector
   typedef struct packed {
      logic freq_high;
      logic freq_low;
      logic curr_high;
      logic curr_low;
      logic fb_high;
      logic fb_low;
      logic ref_high;
      logic ref_low;
   } dlw_warn_t;

   // Register port request
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [31:0] wdata;
   } dlw_req_t;

   // Ramp select towards the ramp generator
   typedef struct packed {
      logic        initial_sel;
      logic [15:0] time_tenths;
   } dlw_ramp_t;

   typedef enum logic [1:0] {
      FL_IDLE = 2'b00,
      FL_WAIT = 2'b01,
      FL_RAMP = 2'b11,
      FL_DONE = 2'b10
   } dlw_fill_st_t;

   typedef enum logic [1:0] {
      IR_IDLE = 2'b00,
      IR_INIT = 2'b01,
      IR_NORM = 2'b11
   } dlw_iramp_st_t;

endpackage : dlw_pkg

// ==== dlw_checker.sv ====
// Concurrent checks on warning gating, routing, read port and sequencer starts.
// Assumes it is bound onto dlw_top and sees only that module's ports.
`timescale 1ns/1ps
module dlw_checker #(
   parameter int unsigned FILL_TICK_CYC = 4
) (
   input wire logic                i_ref_clk,
   input wire logic                i_rst,
   input wire dlw_pkg::dlw_req_t   i_req,
   input wire dlw_pkg::dlw_drive_t i_drive,
   input wire logic [31:0]         o_rdata,
   input wire dlw_pkg::dlw_warn_t  o_warn,
   input wire logic                o_sig_warn,
   input wire logic                o_relay_warn,
   input wire logic signed [31:0]  o_setpoint,
   input wire logic                o_fill_active,
   input wire dlw_pkg::dlw_ramp_t  o_ramp
);
   import dlw_pkg::*;
   logic gate;
   // Warning gate: motor turning and no ramp under way
   assign gate = i_drive.running & ~i_drive.ramp_up & ~i_drive.ramp_down;
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);
   gate_mute_a: assert property (!gate |=> o_warn == '0 ##1 !o_sig_warn && !o_relay_warn)
      else $error("warning shown while gate closed");
   arm_wait_a: assert property (o_warn != '0 |-> $past(gate, 1) && $past(gate, 2))
      else $error("warning shown before arming");
   sig_route_a: assert property (o_sig_warn |-> $past(o_warn) != '0)
      else $error("signal output without warning");
   relay_route_a: assert property (o_relay_warn |-> $past(o_warn) != '0)
      else $error("relay output without warning");
   rdata_idle_a: assert property (!$past(i_req.rd) |-> o_rdata == '0)
      else $error("read data outside read slot");
   iramp_start_a: assert property ($rose(o_ramp.initial_sel) |-> $past(i_drive.start_cmd, 2))
      else $error("initial ramp without start");
   iramp_time_a: assert property (o_ramp.initial_sel |-> o_ramp.time_tenths inside {[16'h0001:16'h0e10]})
      else $error("initial ramp time out of range");
   fill_start_a: assert property ($rose(o_fill_active) |-> $past(i_drive.start_cmd, 1) && $past(i_drive.start_cmd, 2))
      else $error("fill began without start");
   fill_abort_a: assert property (!i_drive.start_cmd |-> ##2 !o_fill_active)
      else $error("fill kept after start loss");
   cover property (o_sig_warn && o_relay_warn);
   cover property ($fell(o_fill_active) && i_drive.start_cmd);
   cover property ($fell(o_ramp.initial_sel) && i_drive.start_cmd);
endmodule : dlw_checker

bind dlw_top dlw_checker #(.FILL_TICK_CYC(FILL_TICK_CYC)) u_chk (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
   .i_req(i_req), .i_drive(i_drive), .o_rdata(o_rdata), .o_warn(o_warn), .o_sig_warn(o_sig_warn),
   .o_relay_warn(o_relay_warn), .o_setpoint(o_setpoint), .o_fill_active(o_fill_active), .o_ramp(o_ramp));

// ==== dlw_plant.sv ====
// Motor model: output frequency ramps toward a target while started.
// Assumes the bench's clock and synchronous reset; the step sets ramp speed.
`timescale 1ns/1ps
module dlw_plant (
   input  wire logic               i_ref_clk,
   input  wire logic               i_rst,
   input  wire logic               i_start,
   input  wire logic signed [31:0] i_target,
   input  wire logic signed [31:0] i_step,
   output logic                    o_running,
   output logic                    o_ramp_up,
   output logic                    o_ramp_down,
   output logic                    o_at_ref,
   output logic signed [31:0]      o_freq
);
   // Frequency integrator, clamped at target and at standstill
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) o_freq <= '0;
      else if (i_start) o_freq <= (o_freq + i_step > i_target) ? i_target : o_freq + i_step;
      else o_freq <= (o_freq > i_step) ? o_freq - i_step : '0;
   end
   // Status flags as the drive core reports them
   assign o_running   = i_start | (o_freq > 0);
   assign o_ramp_up   = i_start & (o_freq < i_target);
   assign o_ramp_down = ~i_start & (o_freq > 0);
   assign o_at_ref    = i_start & (o_freq == i_target);
endmodule : dlw_plant

// ==== tb_top.sv ====
// Self-checking bench of the limit warning, initial ramp and fill block.
// Assumes dlw_plant as the motor and the checker bound onto the design.
`timescale 1ns/1ps
module tb_top;
   import dlw_pkg::*;
   logic               clk = 1'b0;
   logic               rst = 1'b1;
   logic               st = 1'b0;
   dlw_req_t           req = '0;
   dlw_drive_t         drv;
   logic signed [31:0] tgt = 32'sd1000, stp = 32'sd100, fb = '0, rf = '0, cur = 32'sd16, sp, frq;
   logic [31:0]        rdata, ctrl = 32'h4, route = '0;
   dlw_warn_t          warn;
   dlw_ramp_t          rmp;
   logic               sig, rel, fa, run, ru, rdn, atr, g, arm = 1'b0, es = 1'b0, er = 1'b0;
   logic [7:0]         ew = '0, v;
   int                 n_errors = 0, comparisons = 0, k, lo, seed = 32'h316a5701;
   int                 lim[8] = '{-999999999, 999999999, -999999999, 999999999, 0, 999999999, 0, 999999999};
   int                 ofs[8] = '{4, 8, 12, 16, 60, 64, 68, 72};
   int                 cfg[4] = '{4, 6, 7, 5};

   dlw_plant u_plant (.i_ref_clk(clk), .i_rst(rst), .i_start(st), .i_target(tgt), .i_step(stp),
      .o_running(run), .o_ramp_up(ru), .o_ramp_down(rdn), .o_at_ref(atr), .o_freq(frq));
   dlw_top #(.FILL_TICK_CYC(4)) DUT (.i_ref_clk(clk), .i_rst(rst), .i_req(req), .i_drive(drv),
      .o_rdata(rdata), .o_warn(warn), .o_sig_warn(sig), .o_relay_warn(rel), .o_setpoint(sp),
      .o_fill_active(fa), .o_ramp(rmp));
   // Drive-core inputs: motor from the model, references and sensor from the bench
   assign drv = '{run, st, ru, rdn, atr, frq, rf, -rf, rf + 32'sd1, -rf, fb, cur};

   // Clock at 4 ns
   initial forever #2 clk = ~clk;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      req <= '{1'b1, 1'b0, a, d};
      @(posedge clk);
      req <= '0;
      @(posedge clk);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      req <= '{1'b0, 1'b1, a, 32'h0};
      @(posedge clk);
      req <= '0;
      @(posedge clk);
      chk(rdata, e);
   endtask : rd

   task automatic conclude;
      $display("n_errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : conclude

   // Warning model, compared every cycle; snoops register writes
   always @(posedge clk) begin
      if (rst) begin
         ew = '0;
         arm = 1'b0;
      end else begin
         chk(warn, ew);
         chk({er, es}, {rel, sig});
         es = |(ew & route[7:0]);
         er = |(ew & route[15:8]);
         g = drv.running & ~drv.ramp_up & ~drv.ramp_down;
         v = {drv.out_freq > lim[7], drv.out_freq < lim[6], drv.current > lim[5], drv.current < lim[4],
              drv.feedback > lim[3], drv.feedback < lim[2],
              ctrl[1] & ((ctrl[0] ? drv.result_ref_pu : drv.result_ref_hz) > lim[1]),
              ctrl[1] & ((ctrl[0] ? drv.remote_ref_pu : drv.remote_ref_hz) < lim[0])};
         ew = (arm & g) ? v : 8'h00;
         arm = g & (arm | drv.at_reference);
         if (req.wr) begin
            for (int i = 0; i < 8; i++) if (req.addr == 8'(ofs[i])) lim[i] = req.wdata;
            if (req.addr == 8'h00) ctrl = req.wdata;
            if (req.addr == 8'h30) route = req.wdata;
         end
      end
   end

   // Watchdog well past the expected run length
   initial begin
      #80000;
      n_errors++;
      conclude();
   end

   // Main sequence
   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      // Reset values, clamps and an unmapped hole
      rd(8'h04, 32'hc4653601);
      rd(8'h10, 32'h3b9ac9ff);
      rd(8'h18, 32'h0);
      rd(8'h14, 32'h0);
      rd(8'hfc, 32'h0);
      wr(8'h14, 32'hfa0);
      rd(8'h14, 32'he10);
      wr(8'h18, 32'hffff_fffb);
      rd(8'h18, 32'h0);
      wr(8'h28, 32'h64);
      wr(8'h1c, 32'h32);
      rd(8'h1c, 32'h64);
      wr(8'h28, 32'h0);
      // Random limits, routes and signals under four loop setups
      st <= 1'b1;
      for (int p = 0; p < 4; p++) begin
         wr(8'h00, cfg[p]);
         wr(8'h30, $random(seed));
         for (int i = 0; i < 4; i++) begin
            lo = $random(seed) & 127;
            wr(8'(ofs[2 * i + 1]), 32'h3b9ac9ff);
            wr(8'(ofs[2 * i]), lo);
            wr(8'(ofs[2 * i + 1]), lo + ($random(seed) & 255));
         end
         for (k = 0; k < 100; k++) begin
            @(posedge clk);
            rf <= ($random(seed) & 511) - 100;
            fb <= ($random(seed) & 511) - 100;
            cur <= $random(seed) & 511;
            st <= (k & 63) < 54;
            if ((k & 31) == 0) tgt <= $random(seed) & 511;
         end
      end
      // Initial ramp up to minimum frequency, then switched off
      @(posedge clk);
      st <= 1'b0;
      stp <= 32'sd20;
      tgt <= 32'sd1000;
      wr(8'h4c, 32'd500);
      wr(8'h14, 32'he10);
      repeat (60) @(posedge clk);
      st <= 1'b1;
      for (k = 0; k < 20 && rmp.initial_sel !== 1'b1; k++) @(posedge clk);
      chk({rmp.initial_sel, rmp.time_tenths}, 32'h1_0e10);
      for (k = 0; k < 100 && rmp.initial_sel === 1'b1; k++) @(posedge clk);
      chk(frq >= 500 && frq <= 580, 1);
      st <= 1'b0;
      repeat (60) @(posedge clk);
      wr(8'h14, 32'h0);
      st <= 1'b1;
      repeat (20) begin
         @(posedge clk);
         chk(rmp.initial_sel, 0);
      end
      // Fill from sampled feedback toward the filled point, then hand over
      st <= 1'b0;
      stp <= 32'sd100;
      fb <= 32'sd100;
      wr(8'h00, 32'h5);
      wr(8'h18, 32'd5000);
      wr(8'h1c, 32'd2000);
      wr(8'h20, 32'd777);
      wr(8'h24, 32'd888);
      repeat (20) @(posedge clk);
      st <= 1'b1;
      for (k = 0; k < 50 && fa !== 1'b1; k++) @(posedge clk);
      chk({fa, sp[30:0]}, {1'b1, 31'd100});
      repeat (40) @(posedge clk);
      chk(sp >= 145 && sp <= 155, 1);
      fb <= 32'sd2000;
      for (k = 0; k < 10 && fa === 1'b1; k++) @(posedge clk);
      repeat (2) @(posedge clk);
      chk({fa, sp[30:0]}, {1'b0, 31'd777});
      wr(8'h00, 32'hd);
      repeat (2) @(posedge clk);
      chk(sp, 32'd888);
      // Open loop: fill must stay off
      st <= 1'b0;
      repeat (40) @(posedge clk);
      wr(8'h00, 32'h4);
      st <= 1'b1;
      repeat (40) begin
         @(posedge clk);
         chk(fa, 0);
      end
      conclude();
   end
endmodule : tb_top
